// *** bench/bus_port_monitor.sv ***
`include "bus_port_defs.svh"

module bus_port_monitor (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               rst_pin_n,
    input  wire logic               cs_n,
    input  wire logic               rd_n,
    input  wire logic               wr_n,
    input  wire logic               dack_n,
    input  wire logic [`ADDR_W-1:0] addr,
    input  wire logic               dev_oe,
    input  wire logic               dreq,
    input  wire logic               irq
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] rise_gap_ff;
    logic [7:0] dack_gap_ff;
    logic [7:0] fifo_gap_ff;
    logic [7:0] pin_low_ff;
    logic [7:0] start_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    function automatic logic [7:0] sat(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction

    // cycle counters saturate, so a quiet link never wraps into a false hit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rise_gap_ff <= 8'hff;
            dack_gap_ff <= 8'hff;
            fifo_gap_ff <= 8'hff;
            pin_low_ff  <= 8'h00;
            start_ff    <= 8'h00;
        end else begin
            rise_gap_ff <= $rose(dreq) ? 8'h01 : sat(rise_gap_ff);
            dack_gap_ff <= $rose(dack_n) ? 8'h01 : sat(dack_gap_ff);
            fifo_gap_ff <= ($fell(dack_n) || ($fell(cs_n) && addr == `FIFO_ADDR)) ?
                           8'h01 : sat(fifo_gap_ff);
            pin_low_ff  <= rst_pin_n ? 8'h00 : sat(pin_low_ff);
            start_ff    <= rst_pin_n ? sat(start_ff) : 8'h00;
        end
    end

    a_cpu_write_quiet: assert property (dev_oe |-> wr_n)
        else $error("device drives data during a write");
    a_read_drive_win: assert property ($rose(dev_oe) |->
        !rd_n && (!cs_n || !dack_n))
        else $error("read drive outside a read window");
    a_read_drive_end: assert property ($rose(rd_n) |-> ##[0:4] !dev_oe)
        else $error("read drive held after the window");
    a_ack_on_request: assert property ($fell(dack_n) |-> dreq)
        else $error("acknowledge without request");
    a_dreq_drops: assert property ($fell(dack_n) |-> ##2 (!dreq)[*3])
        else $error("request held after acknowledge");
    a_dreq_high_width: assert property ($rose(dreq) |->
        rise_gap_ff >= `TWH_DREQ_CYC)
        else $error("request raised again too soon");
    a_dreq_after_ack: assert property ($rose(dreq) |-> dack_gap_ff >= `TD_DACK_CYC)
        else $error("request raised too soon after acknowledge");
    a_fifo_cycle_gap: assert property (($fell(dack_n) || ($fell(cs_n) &&
        addr == `FIFO_ADDR)) |-> fifo_gap_ff >= `TW_CYCLE_CYC)
        else $error("fifo accesses too close");
    a_reset_pin_width: assert property ($rose(rst_pin_n) |-> pin_low_ff >= `TW_RST_CYC)
        else $error("reset pin pulse too short");
    a_start_after_rst: assert property (($fell(cs_n) || $fell(dack_n)) |->
        start_ff >= `TST_RST_CYC)
        else $error("strobe too soon after reset");
    a_irq_clear_write: assert property ($rose(wr_n) && $past(!cs_n) |-> ##[1:6] !irq)
        else $error("interrupt not cleared by write");
endmodule

// *** bench/tb_top.sv ***
`include "bus_port_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic                clk;
    logic                rst_n = 1'b0;
    logic                cmd_valid = 1'b0;
    logic                cmd_write = 1'b0;
    logic [`ADDR_W-1:0]  cmd_addr = '0;
    logic [`DATA_W-1:0]  cmd_wdata = '0;
    logic                dma_en = 1'b0;
    logic                dma_mode = 1'b0;
    logic                dma_to_fifo = 1'b0;
    logic [`DATA_W-1:0]  dma_wdata = 16'h3c00;
    logic                int_set = 1'b0;
    logic                fifo_space = 1'b1;
    logic                fifo_avail = 1'b1;
    logic                gap_clr = 1'b0;
    logic                cmd_ready, rsp_valid, dma_wtaken, dma_rvalid, irq_h;
    logic                reg_wr, reg_rd, fifo_wr, fifo_rd, dreq_q, dack_q;
    logic [`ADDR_W-1:0]  reg_addr;
    logic [`DATA_W-1:0]  rsp_rdata, dma_rdata, reg_wdata, reg_rdata, fifo_wdata, fifo_rdata;
    int                  checks, mismatches, n_regwr, n_regrd, n_fwr, n_frd, n_taken, n_rval;
    int                  dack_gap = 1000;
    int                  gap_min = 1000;
    realtime             last_take;

    bus_port_if port_bus ();

    usb_dev_port i_usb_dev_port (.clk, .rst_n, .port(port_bus.device_mp), .reg_addr, .reg_wr,
        .reg_wdata, .reg_rd, .reg_rdata, .int_set, .dma_en, .dma_mode, .dma_to_fifo,
        .fifo_space, .fifo_wr, .fifo_wdata, .fifo_avail, .fifo_rdata, .fifo_rd);

    usb_host_port i_usb_host_port (.clk, .rst_n, .port(port_bus.host_mp), .cmd_valid,
        .cmd_ready, .cmd_write, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_rdata, .dma_en,
        .dma_mode, .dma_to_fifo, .dma_wdata, .dma_wtaken, .dma_rvalid, .dma_rdata, .irq(irq_h));

    bus_port_monitor i_bus_port_monitor (.clk, .rst_n, .rst_pin_n(port_bus.rst_pin_n),
        .cs_n(port_bus.cs_n), .rd_n(port_bus.rd_n), .wr_n(port_bus.wr_n),
        .dack_n(port_bus.dack_n), .addr(port_bus.addr), .dev_oe(port_bus.dev_oe),
        .dreq(port_bus.dreq), .irq(port_bus.irq));

    // register file and fifo stand-ins; fifo head word is 16'hc000 plus its read index
    assign reg_rdata  = 16'h5a00 | {9'h000, reg_addr};
    assign fifo_rdata = 16'hc000 + 16'(n_frd);

    task automatic check(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            mismatches++;
            $display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, n, lim);
            stop_test();
        end
    endtask

    // tallies and word order; counters move by nba so the fifo model stays race free
    always @(posedge clk) begin
        if (reg_wr) n_regwr <= n_regwr + 1;
        if (reg_rd) n_regrd <= n_regrd + 1;
        if (fifo_rd) n_frd <= n_frd + 1;
        if (dma_wtaken) dma_wdata <= dma_wdata + 16'h0001;
        if (dma_wtaken) n_taken <= n_taken + 1;
        if (dma_rvalid) n_rval <= n_rval + 1;
        if (fifo_wr) n_fwr <= n_fwr + 1;
        if (fifo_wr) check(fifo_wdata, 16'h3c00 + 16'(n_fwr));
        if (dma_rvalid) check(dma_rdata, 16'hc000 + 16'(n_rval));
    end

    // shortest wait from acknowledge release to the next request
    always @(posedge clk) begin
        dreq_q <= port_bus.dreq;
        dack_q <= port_bus.dack_n;
        dack_gap <= (port_bus.dack_n && !dack_q) ? 1 : dack_gap + 1;
        if (gap_clr) gap_min <= 1000;
        else if (port_bus.dreq && !dreq_q && dack_gap < gap_min) gap_min <= dack_gap;
    end

    task automatic cmd(input logic w, input logic [`ADDR_W-1:0] a,
                       input logic [`DATA_W-1:0] d, output logic [`DATA_W-1:0] r);
        int n;
        @(posedge clk);
        cmd_write <= w;
        cmd_addr  <= a;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(negedge clk);
            if (cmd_ready === 1'b1) break;
        end
        bound(n, 300);
        @(posedge clk);
        cmd_valid <= 1'b0;
        last_take = $realtime;
        for (n = 0; n < 50 && rsp_valid !== 1'b1; n++) @(negedge clk);
        bound(n, 50);
        r = rsp_rdata;
        // device side pulses land two cycles after the answer
        repeat (4) @(negedge clk);
    endtask

    task automatic s_regs();
        logic [`DATA_W-1:0] r;
        realtime            t0;
        cmd(1'b1, 7'h05, 16'h1234, r);
        check(16'(n_regwr), 16'h0001);
        check(reg_wdata, 16'h1234);
        check(16'(reg_addr), 16'h0005);
        cmd(1'b0, 7'h11, 16'h0000, r);
        check(r, 16'h5a11);
        check(16'(n_regrd), 16'h0001);
        check(16'(n_regwr), 16'h0001);
        cmd(1'b1, `FIFO_ADDR, 16'h0bad, r);
        t0 = last_take;
        cmd(1'b1, `FIFO_ADDR, 16'h0bad, r);
        check(16'(last_take - t0 >= `TW_CYCLE_NS), 16'h0001);
    endtask

    task automatic s_irq();
        logic [`DATA_W-1:0] r;
        @(posedge clk);
        int_set <= 1'b1;
        @(posedge clk);
        int_set <= 1'b0;
        repeat (4) @(negedge clk);
        check(16'(port_bus.irq), 16'h0001);
        check(16'(irq_h), 16'h0001);
        cmd(1'b1, 7'h02, 16'h0000, r);
        check(16'(port_bus.irq), 16'h0000);
        repeat (3) @(negedge clk);
        check(16'(irq_h), 16'h0000);
    endtask

    // four words through the request pair, then let the last one drain
    task automatic s_dma(input logic mode, input logic to_fifo);
        int n;
        int h0;
        @(posedge clk);
        dma_mode    <= mode;
        dma_to_fifo <= to_fifo;
        gap_clr     <= 1'b1;
        dma_en      <= 1'b1;
        @(posedge clk);
        gap_clr <= 1'b0;
        h0 = to_fifo ? n_taken : n_rval;
        for (n = 0; n < 400 && (to_fifo ? n_taken : n_rval) < h0 + 4; n++) @(negedge clk);
        bound(n, 400);
        @(posedge clk);
        dma_en <= 1'b0;
        repeat (40) @(negedge clk);
        if (to_fifo) check(16'(n_fwr), 16'(n_taken));
        else check(16'(n_frd), 16'(n_rval));
        check(16'(gap_min >= (mode ? `TD_DACK_CYC : `TD_CTRL_CYC)), 16'h0001);
    endtask

    // no room, no word, or dma off: request must stay down
    task automatic s_refuse();
        logic [3:0] cfg [3] = '{4'b1101, 4'b1010, 4'b0111};
        int         hi;
        int         w0;
        foreach (cfg[i]) begin
            @(posedge clk);
            {dma_en, dma_to_fifo, fifo_space, fifo_avail} <= cfg[i];
            w0 = n_fwr + n_frd;
            hi = 0;
            repeat (40) @(negedge clk) if (port_bus.dreq !== 1'b0) hi++;
            check(16'(hi), 16'h0000);
            check(16'(n_fwr + n_frd - w0), 16'h0000);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        s_regs();
        s_irq();
        s_dma(1'b0, 1'b1);
        s_dma(1'b1, 1'b1);
        s_dma(1'b0, 1'b0);
        s_dma(1'b1, 1'b0);
        s_refuse();
        stop_test();
    end
endmodule

// *** hdl/usb_dev_port.sv ***
`include "bus_port_defs.svh"

module usb_dev_port
    import bus_port_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    bus_port_if.device_mp             port,
    output logic [`ADDR_W-1:0]        reg_addr,
    output logic                      reg_wr,
    output logic [`DATA_W-1:0]        reg_wdata,
    output logic                      reg_rd,
    input  wire logic [`DATA_W-1:0]   reg_rdata,
    input  wire logic                 int_set,
    input  wire logic                 dma_en,
    input  wire logic                 dma_mode,
    input  wire logic                 dma_to_fifo,
    input  wire logic                 fifo_space,
    output logic                      fifo_wr,
    output logic [`DATA_W-1:0]        fifo_wdata,
    input  wire logic                 fifo_avail,
    input  wire logic [`DATA_W-1:0]   fifo_rdata,
    output logic                      fifo_rd
);

    localparam int SW = 5 + `ADDR_W + `DATA_W;

    logic [SW-1:0]          sync1_ff;
    logic [SW-1:0]          sync2_ff;
    logic                   pin_rst_n_s;
    logic                   cs_n_s;
    logic                   rd_n_s;
    logic                   wr_n_s;
    logic                   dack_n_s;
    logic [`ADDR_W-1:0]     addr_s;
    logic [`DATA_W-1:0]     data_s;
    logic                   dev_rst;
    logic                   cpu_wr_win;
    logic                   cpu_rd_win;
    logic                   dma_wr_win;
    logic                   dma_rd_win;
    logic [3:0]             win_ff;
    logic                   cpu_wr_end;
    logic                   cpu_rd_end;
    logic                   dma_wr_end;
    logic                   dma_rd_end;
    logic [`ADDR_W-1:0]     addr_ff;
    logic [`DATA_W-1:0]     wdata_ff;
    logic [`DATA_W-1:0]     dout_ff;
    logic                   oe_ff;
    logic                   irq_ff;
    dma_st_t                dma_st_ff;
    dma_st_t                nxt_dma_st;
    logic [`CNT_W-1:0]      hi_cnt_ff;
    logic [`CNT_W-1:0]      gap_cnt_ff;
    logic                   xfer_ready;
    logic                   gap_done;

    // every pin crosses two flops; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
        end else begin
            sync1_ff <= {port.rst_pin_n, port.cs_n, port.rd_n, port.wr_n,
                         port.dack_n, port.addr, port.bus_d};
            sync2_ff <= sync1_ff;
        end
    end

    assign {pin_rst_n_s, cs_n_s, rd_n_s, wr_n_s, dack_n_s, addr_s, data_s} = sync2_ff;

    // the reset pin from the host joins the local reset
    assign dev_rst = !rst_n || !pin_rst_n_s;

    // overlap windows of the active-low strobes
    assign cpu_wr_win = !cs_n_s && !wr_n_s;
    assign cpu_rd_win = !cs_n_s && !rd_n_s;
    assign dma_wr_win = !dack_n_s && !wr_n_s;
    assign dma_rd_win = !dack_n_s && !rd_n_s;

    // previous window state, for end-of-overlap detection
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            win_ff <= 4'h0;
        end else begin
            win_ff <= {dma_rd_win, dma_wr_win, cpu_rd_win, cpu_wr_win};
        end
    end

    // an access completes when its overlap ends
    assign cpu_wr_end = win_ff[0] && !cpu_wr_win;
    assign cpu_rd_end = win_ff[1] && !cpu_rd_win;
    assign dma_wr_end = win_ff[2] && !dma_wr_win;
    assign dma_rd_end = win_ff[3] && !dma_rd_win;

    // address and write data follow the bus only inside an overlap,
    // so the value at the closing edge is what gets used
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            addr_ff  <= '0;
            wdata_ff <= '0;
        end else begin
            if (cpu_wr_win || cpu_rd_win) begin
                addr_ff <= addr_s;
            end
            if (cpu_wr_win || dma_wr_win) begin
                wdata_ff <= data_s;
            end
        end
    end

    // completion strobes to the core
    assign reg_addr   = addr_ff;
    assign reg_wdata  = wdata_ff;
    assign fifo_wdata = wdata_ff;
    assign reg_wr     = cpu_wr_end;
    assign reg_rd     = cpu_rd_end;
    assign fifo_wr    = dma_wr_end && (dma_st_ff == D_XFER);
    assign fifo_rd    = dma_rd_end && (dma_st_ff == D_XFER);

    // read drive: enable and data move together, one flop behind the window
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            oe_ff   <= 1'b0;
            dout_ff <= '0;
        end else begin
            oe_ff <= cpu_rd_win || dma_rd_win;
            if (dma_rd_win) begin
                dout_ff <= fifo_rdata;
            end else if (cpu_rd_win) begin
                dout_ff <= reg_rdata;
            end
        end
    end

    assign port.dev_oe = oe_ff;
    assign port.dev_d  = dout_ff;

    // interrupt: any register write clears it, a new event wins
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            irq_ff <= 1'b0;
        end else if (int_set) begin
            irq_ff <= 1'b1;
        end else if (cpu_wr_end) begin
            irq_ff <= 1'b0;
        end
    end

    assign port.irq = irq_ff;

    // room to move a word in the selected direction
    assign xfer_ready = dma_en && (dma_to_fifo ? fifo_space : fifo_avail);

    // both the high-width and the per-mode delay must have run out
    assign gap_done = (hi_cnt_ff >= `CNT_W'(`TWH_DREQ_CYC)) &&
                      (gap_cnt_ff >= (dma_mode ? `CNT_W'(`TD_DACK_CYC)
                                               : `CNT_W'(`TD_CTRL_CYC)));

    // request sequencer
    always_comb begin
        nxt_dma_st = dma_st_ff;
        unique case (dma_st_ff)
            D_IDLE: begin
                if (xfer_ready) begin
                    nxt_dma_st = D_REQ;
                end
            end
            D_REQ: begin
                if (!dack_n_s) begin
                    nxt_dma_st = D_XFER;
                end else if (!xfer_ready) begin
                    nxt_dma_st = D_IDLE;
                end
            end
            D_XFER: begin
                if (dma_wr_end || dma_rd_end) begin
                    nxt_dma_st = dma_mode ? D_REL : D_GAP;
                end else if (dack_n_s) begin
                    nxt_dma_st = D_GAP;
                end
            end
            D_REL: begin
                if (dack_n_s) begin
                    nxt_dma_st = D_GAP;
                end
            end
            D_GAP: begin
                if (gap_done) begin
                    nxt_dma_st = D_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (dev_rst) begin
            dma_st_ff <= D_IDLE;
        end else begin
            dma_st_ff <= nxt_dma_st;
        end
    end

    // high-width timer runs from the raise; gap timer from entry to gap
    always_ff @(posedge clk) begin
        if (dev_rst) begin
            hi_cnt_ff  <= '0;
            gap_cnt_ff <= '0;
        end else begin
            if (dma_st_ff == D_IDLE && nxt_dma_st == D_REQ) begin
                hi_cnt_ff <= '0;
            end else if (hi_cnt_ff != '1) begin
                hi_cnt_ff <= hi_cnt_ff + 1'b1;
            end
            if (dma_st_ff != D_GAP) begin
                gap_cnt_ff <= '0;
            end else if (gap_cnt_ff != '1) begin
                gap_cnt_ff <= gap_cnt_ff + 1'b1;
            end
        end
    end

    // request falls as soon as the synced acknowledge is seen low
    assign port.dreq = (dma_st_ff == D_REQ) && dack_n_s;

endmodule

// *** hdl/usb_host_port.sv ***
`include "bus_port_defs.svh"

module usb_host_port
    import bus_port_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    bus_port_if.host_mp               port,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire logic                 cmd_write,
    input  wire logic [`ADDR_W-1:0]   cmd_addr,
    input  wire logic [`DATA_W-1:0]   cmd_wdata,
    output logic                      rsp_valid,
    output logic [`DATA_W-1:0]        rsp_rdata,
    input  wire logic                 dma_en,
    input  wire logic                 dma_mode,
    input  wire logic                 dma_to_fifo,
    input  wire logic [`DATA_W-1:0]   dma_wdata,
    output logic                      dma_wtaken,
    output logic                      dma_rvalid,
    output logic [`DATA_W-1:0]        dma_rdata,
    output logic                      irq
);

    localparam int SW = 2 + `DATA_W;

    logic [SW-1:0]          sync1_ff;
    logic [SW-1:0]          sync2_ff;
    logic                   dreq_s;
    logic                   irq_s;
    logic [`DATA_W-1:0]     data_s;
    host_st_t               st_ff;
    logic [`CNT_W-1:0]      cnt_ff;
    logic [`CNT_W-1:0]      fifo_gap_ff;
    logic                   fifo_ok;
    logic                   take_dma;
    logic                   take_cmd;
    logic                   is_dma_ff;
    logic                   is_wr_ff;
    logic                   rst_pin_n_ff;
    logic                   cs_n_ff;
    logic                   rd_n_ff;
    logic                   wr_n_ff;
    logic                   dack_n_ff;
    logic [`ADDR_W-1:0]     addr_ff;
    logic [`DATA_W-1:0]     hd_ff;
    logic                   hoe_ff;
    logic                   rsp_valid_ff;
    logic                   dma_wtaken_ff;
    logic                   dma_rvalid_ff;
    logic [`DATA_W-1:0]     rdata_ff;

    // device pins cross two flops before use
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {port.dreq, port.irq, port.bus_d};
            sync2_ff <= sync1_ff;
        end
    end

    assign {dreq_s, irq_s, data_s} = sync2_ff;
    assign irq = irq_s;

    // fifo spacing counted from the start of the last fifo strobe
    assign fifo_ok  = fifo_gap_ff >= `CNT_W'(`TW_CYCLE_CYC);
    assign take_dma = (st_ff == H_IDLE) && dma_en && dreq_s && fifo_ok;
    assign take_cmd = (st_ff == H_IDLE) && !take_dma && cmd_valid &&
                      (cmd_addr != `FIFO_ADDR || fifo_ok);
    assign cmd_ready = take_cmd;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_gap_ff <= '1;
        end else if (take_dma || (take_cmd && cmd_addr == `FIFO_ADDR)) begin
            fifo_gap_ff <= '0;
        end else if (fifo_gap_ff != '1) begin
            fifo_gap_ff <= fifo_gap_ff + 1'b1;
        end
    end

    // access sequencer; pins come straight from flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff         <= H_RST;
            cnt_ff        <= '0;
            is_dma_ff     <= 1'b0;
            is_wr_ff      <= 1'b0;
            rst_pin_n_ff  <= 1'b0;
            cs_n_ff       <= 1'b1;
            rd_n_ff       <= 1'b1;
            wr_n_ff       <= 1'b1;
            dack_n_ff     <= 1'b1;
            addr_ff       <= '0;
            hd_ff         <= '0;
            hoe_ff        <= 1'b0;
            rsp_valid_ff  <= 1'b0;
            dma_wtaken_ff <= 1'b0;
            dma_rvalid_ff <= 1'b0;
            rdata_ff      <= '0;
        end else begin
            cnt_ff        <= cnt_ff + 1'b1;
            rsp_valid_ff  <= 1'b0;
            dma_wtaken_ff <= 1'b0;
            dma_rvalid_ff <= 1'b0;
            unique case (st_ff)
                H_RST: begin
                    if (cnt_ff >= `CNT_W'(`TW_RST_CYC - 1)) begin
                        rst_pin_n_ff <= 1'b1;
                        cnt_ff       <= '0;
                        st_ff        <= H_START;
                    end
                end
                H_START: begin
                    // no strobe until the start time has passed
                    if (cnt_ff >= `CNT_W'(`TST_RST_CYC - 1)) begin
                        st_ff <= H_IDLE;
                    end
                end
                H_IDLE: begin
                    cnt_ff <= '0;
                    if (take_dma) begin
                        st_ff      <= H_STB;
                        is_dma_ff  <= 1'b1;
                        is_wr_ff   <= dma_to_fifo;
                        dack_n_ff  <= 1'b0;
                        wr_n_ff    <= !dma_to_fifo;
                        rd_n_ff    <= dma_to_fifo;
                        hd_ff      <= dma_wdata;
                        hoe_ff     <= dma_to_fifo;
                    end else if (take_cmd) begin
                        st_ff      <= H_STB;
                        is_dma_ff  <= 1'b0;
                        is_wr_ff   <= cmd_write;
                        cs_n_ff    <= 1'b0;
                        wr_n_ff    <= !cmd_write;
                        rd_n_ff    <= cmd_write;
                        addr_ff    <= cmd_addr;
                        hd_ff      <= cmd_wdata;
                        hoe_ff     <= cmd_write;
                    end
                end
                H_STB: begin
                    // hold the overlap; read data sampled at its last cycle
                    if (cnt_ff >= `CNT_W'(`HOST_STB_CYC - 1)) begin
                        cnt_ff  <= '0;
                        st_ff   <= H_REC;
                        cs_n_ff <= 1'b1;
                        rd_n_ff <= 1'b1;
                        wr_n_ff <= 1'b1;
                        if (!dma_mode) begin
                            dack_n_ff <= 1'b1;
                        end
                        if (!is_wr_ff) begin
                            rdata_ff <= data_s;
                        end
                        rsp_valid_ff  <= !is_dma_ff;
                        dma_wtaken_ff <= is_dma_ff && is_wr_ff;
                        dma_rvalid_ff <= is_dma_ff && !is_wr_ff;
                    end
                end
                H_REC: begin
                    // recovery; one-word mode lets acknowledge go afterwards
                    if (cnt_ff >= `CNT_W'(`TREC_CTRL_CYC - 1)) begin
                        st_ff     <= H_IDLE;
                        dack_n_ff <= 1'b1;
                        hoe_ff    <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign port.rst_pin_n = rst_pin_n_ff;
    assign port.cs_n      = cs_n_ff;
    assign port.rd_n      = rd_n_ff;
    assign port.wr_n      = wr_n_ff;
    assign port.dack_n    = dack_n_ff;
    assign port.addr      = addr_ff;
    assign port.host_d    = hd_ff;
    assign port.host_oe   = hoe_ff;
    assign rsp_valid      = rsp_valid_ff;
    assign rsp_rdata      = rdata_ff;
    assign dma_wtaken     = dma_wtaken_ff;
    assign dma_rvalid     = dma_rvalid_ff;
    assign dma_rdata      = rdata_ff;

endmodule

// *** pkg/bus_port_defs.svh ***
`ifndef BUS_PORT_DEFS_SVH
`define BUS_PORT_DEFS_SVH

// bus widths and the one fifo window address
`define DATA_W          16
`define ADDR_W          7
`define FIFO_ADDR       7'h00
`define CNT_W           8

// clock rate and printed times
`define CLK_MHZ         100
`define TW_CTRL_NS      30
`define TREC_CTRL_NS    30
`define TW_CYCLE_NS     200
`define TW_RST_NS       100
`define TST_RST_NS      100
`define TWH_DREQ_NS     60
`define TD_CTRL_DREQ_NS 60
`define TD_DACK_DREQ_NS 20

// least times round up to whole cycles
`define MIN_CYC(ns)     (((ns) * `CLK_MHZ + 999) / 1000)
`define TW_CTRL_CYC     `MIN_CYC(`TW_CTRL_NS)
`define TREC_CTRL_CYC   `MIN_CYC(`TREC_CTRL_NS)
`define TW_CYCLE_CYC    `MIN_CYC(`TW_CYCLE_NS)
`define TW_RST_CYC      `MIN_CYC(`TW_RST_NS)
`define TST_RST_CYC     `MIN_CYC(`TST_RST_NS)
`define TWH_DREQ_CYC    `MIN_CYC(`TWH_DREQ_NS)
`define TD_CTRL_CYC     `MIN_CYC(`TD_CTRL_DREQ_NS)
`define TD_DACK_CYC     `MIN_CYC(`TD_DACK_DREQ_NS)

// host strobe length: covers both synchroniser paths for read data
`define HOST_STB_CYC    8

`endif

// *** pkg/bus_port_if.sv ***
`include "bus_port_defs.svh"

interface bus_port_if;
    logic                 rst_pin_n;
    logic                 cs_n;
    logic                 rd_n;
    logic                 wr_n;
    logic                 dack_n;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   host_d;
    logic                 host_oe;
    logic [`DATA_W-1:0]   dev_d;
    logic                 dev_oe;
    logic [`DATA_W-1:0]   bus_d;
    logic                 dreq;
    logic                 irq;

    // shared data wire; an undriven bus reads as zero
    assign bus_d = dev_oe ? dev_d : (host_oe ? host_d : '0);

    modport device_mp (
        input  rst_pin_n, cs_n, rd_n, wr_n, dack_n, addr, bus_d,
        output dev_d, dev_oe, dreq, irq
    );

    modport host_mp (
        output rst_pin_n, cs_n, rd_n, wr_n, dack_n, addr, host_d, host_oe,
        input  bus_d, dreq, irq
    );
endinterface

// *** pkg/bus_port_pkg.sv ***
package bus_port_pkg;

    // device dma request sequencer
    typedef enum logic [2:0] {
        D_IDLE,
        D_REQ,
        D_XFER,
        D_REL,
        D_GAP
    } dma_st_t;

    // host access sequencer
    typedef enum logic [2:0] {
        H_RST,
        H_START,
        H_IDLE,
        H_STB,
        H_REC
    } host_st_t;

endpackage
